// ---- rtl/ext_irq_pkg.sv ----
// How it works
// - Upper sources 4..7 request only when mask bit and global enable are set
// - Upper pins are sampled before edge detection; pulses over one clock are caught; the code compares the live pin with its last sample
// - An enabled level-sensed source requests for as long as its pin is low
// - Upper sense field: 00 low, 01 any change, 10 falling, 11 rising
// - Mask register holds one enable bit per source, bit n for source n
// - Pin activity triggers requests even while the pin is driven as an output
// - An edge or change that triggers a request sets the source's flag
// - Flag, mask and global enable together signal the CPU to take the vector
// - Flag clears on vector entry or software write of one; zero does nothing
// - A level-sensed source keeps its flag cleared at all times
// - Sleep with lower sources disabled gates their input buffers, may set flags
// - Group enable plus global enable lets any masked pin change interrupt
// - All eight pin-change inputs share one vector for group 0
// - A pin change sets the group flag; vector entry or write of one clears it
// - Pin-change mask has one bit per input; set enables, clear disables
// - Lower sense field: 00 low, 01 any edge, 10 falling, 11 rising
// - Pin-change events are detected only by sampling on the running I/O clock
// - Upper edges need the running I/O clock; low level works without it
package ext_irq_pkg;

    localparam logic [2:0] OFS_LOWER_SENSE = 3'h0;
    localparam logic [2:0] OFS_UPPER_SENSE = 3'h1;
    localparam logic [2:0] OFS_MASK        = 3'h2;
    localparam logic [2:0] OFS_FLAGS       = 3'h3;
    localparam logic [2:0] OFS_PC_CONTROL  = 3'h4;
    localparam logic [2:0] OFS_PC_FLAGS    = 3'h5;
    localparam logic [2:0] OFS_PC_MASK     = 3'h6;

    localparam logic [7:0]  REG_RESET      = 8'h00;
    localparam logic [31:0] UNMAPPED_READ  = 32'h00000000;
    localparam int          GROUP_BIT      = 0;

    localparam logic [1:0] SENSE_LOW     = 2'h0;
    localparam logic [1:0] SENSE_ANY     = 2'h1;
    localparam logic [1:0] SENSE_FALLING = 2'h2;
    localparam logic [1:0] SENSE_RISING  = 2'h3;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } bus_state_t;

    typedef struct packed {
        logic [7:0] lower_sense_control;
        logic [7:0] upper_sense_control;
        logic [7:0] ext_interrupt_mask;
        logic [7:0] ext_interrupt_flags;
        logic [7:0] pin_change_control;
        logic [7:0] pin_change_flags;
        logic [7:0] pin_change_mask;
    } regs_t;

endpackage

// ---- rtl/external_pin_interrupt_ctrl.sv ----
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
module external_pin_interrupt_ctrl (
    // Clock, reset, enable
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        clk_en,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Pins
    input  wire logic [7:0]  ext_irq_pin,
    input  wire logic [7:0]  pin_change_inputs,
    // CPU side
    input  wire logic        global_irq_enable,
    input  wire logic        sleep_entry,
    input  wire logic [7:0]  ext_irq_ack,
    input  wire logic        pin_change_ack,
    output logic [7:0]       ext_irq_request,
    output logic             pin_change_vector,
    output logic [3:0]       lower_buffer_enable
);

    ////////////////////////////////////////////////////////////////////////
    ext_irq_pkg::regs_t      regs;
    ext_irq_pkg::regs_t      next_regs;
    ext_irq_pkg::bus_state_t bus_state;
    ext_irq_pkg::bus_state_t next_bus_state;
    logic [31:0] next_readdata;
    logic [7:0]  pin_sample;
    logic [7:0]  pc_sample;
    logic [3:0]  buffers_off;
    logic [3:0]  next_buffers_off;
    logic [7:0]  pin_seen;
    logic [7:0]  trig;
    logic [7:0]  level_mode;
    logic [7:0]  low_now;
    logic        pc_trig;
    logic [2:0]  idx;
    logic        wr_hit;
    logic        rd_hit;
    logic [7:0]  wbyte;

    assign idx    = avs_address[4:2];
    // Writes land at the answering edge, where the master sees waitrequest low
    assign wr_hit = avs_write && bus_state == ext_irq_pkg::BUS_DONE && avs_byteenable[0];
    assign rd_hit = avs_read && bus_state == ext_irq_pkg::BUS_IDLE;
    assign wbyte  = avs_writedata[7:0];

    // One wait state: the request is taken in the idle cycle, answered next
    assign avs_waitrequest = (avs_read || avs_write) && bus_state == ext_irq_pkg::BUS_IDLE;

    ////////////////////////////////////////////////////////////////////////
    // Lower pins read through their input buffers; gated buffers read high
    assign pin_seen = {ext_irq_pin[7:4], ext_irq_pin[3:0] | buffers_off};
    assign lower_buffer_enable = ~buffers_off;

    always_comb begin
        trig = 8'h00;
        level_mode = 8'h00;
        low_now = 8'h00;
        for (int n = 0; n < 8; n++) begin
            logic [1:0] sense;
            logic       prev;
            logic       cur;
            sense = (n < 4) ? regs.lower_sense_control[2*(n%4) +: 2]
                            : regs.upper_sense_control[2*(n%4) +: 2];
            prev = pin_sample[n];
            cur  = pin_seen[n];
            low_now[n] = ~cur;
            // Edge compare between the last sample and the live pin, also on pins driven as outputs
            case (sense)
                ext_irq_pkg::SENSE_LOW: begin
                    level_mode[n] = 1'b1;
                end
                ext_irq_pkg::SENSE_ANY: begin
                    trig[n] = prev ^ cur;
                end
                ext_irq_pkg::SENSE_FALLING: begin
                    trig[n] = prev & ~cur;
                end
                default: begin
                    trig[n] = ~prev & cur;
                end
            endcase
        end
    end

    // Pin-change: only masked inputs contribute to the single group event
    assign pc_trig = |((pc_sample ^ pin_change_inputs) & regs.pin_change_mask);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_regs = regs;
        next_bus_state = ext_irq_pkg::BUS_IDLE;
        next_readdata = avs_readdata;
        next_buffers_off = buffers_off;
        if (sleep_entry) begin
            next_buffers_off = ~regs.ext_interrupt_mask[3:0];
        end else begin
            next_buffers_off = 4'h0;
        end
        if (rd_hit || (avs_write && bus_state == ext_irq_pkg::BUS_IDLE)) begin
            next_bus_state = ext_irq_pkg::BUS_DONE;
        end
        if (rd_hit) begin
            if (idx == ext_irq_pkg::OFS_LOWER_SENSE) begin
                next_readdata = {24'h000000, regs.lower_sense_control};
            end else if (idx == ext_irq_pkg::OFS_UPPER_SENSE) begin
                next_readdata = {24'h000000, regs.upper_sense_control};
            end else if (idx == ext_irq_pkg::OFS_MASK) begin
                next_readdata = {24'h000000, regs.ext_interrupt_mask};
            end else if (idx == ext_irq_pkg::OFS_FLAGS) begin
                next_readdata = {24'h000000, regs.ext_interrupt_flags};
            end else if (idx == ext_irq_pkg::OFS_PC_CONTROL) begin
                next_readdata = {24'h000000, regs.pin_change_control};
            end else if (idx == ext_irq_pkg::OFS_PC_FLAGS) begin
                next_readdata = {24'h000000, regs.pin_change_flags};
            end else if (idx == ext_irq_pkg::OFS_PC_MASK) begin
                next_readdata = {24'h000000, regs.pin_change_mask};
            end else begin
                next_readdata = ext_irq_pkg::UNMAPPED_READ;
            end
        end
        // Flag clears first, so a same-cycle event below wins over them
        if (wr_hit) begin
            if (idx == ext_irq_pkg::OFS_LOWER_SENSE) begin
                next_regs.lower_sense_control = wbyte;
            end else if (idx == ext_irq_pkg::OFS_UPPER_SENSE) begin
                next_regs.upper_sense_control = wbyte;
            end else if (idx == ext_irq_pkg::OFS_MASK) begin
                next_regs.ext_interrupt_mask = wbyte;
            end else if (idx == ext_irq_pkg::OFS_FLAGS) begin
                next_regs.ext_interrupt_flags = regs.ext_interrupt_flags & ~wbyte;
            end else if (idx == ext_irq_pkg::OFS_PC_CONTROL) begin
                next_regs.pin_change_control = {7'h00, wbyte[ext_irq_pkg::GROUP_BIT]};
            end else if (idx == ext_irq_pkg::OFS_PC_FLAGS) begin
                next_regs.pin_change_flags = regs.pin_change_flags & ~{7'h00, wbyte[0]};
            end else if (idx == ext_irq_pkg::OFS_PC_MASK) begin
                next_regs.pin_change_mask = wbyte;
            end
        end
        next_regs.ext_interrupt_flags = next_regs.ext_interrupt_flags & ~ext_irq_ack;
        next_regs.ext_interrupt_flags = next_regs.ext_interrupt_flags | trig;
        next_regs.ext_interrupt_flags = next_regs.ext_interrupt_flags & ~level_mode;
        if (pin_change_ack) begin
            next_regs.pin_change_flags[0] = 1'b0;
        end
        if (pc_trig) begin
            next_regs.pin_change_flags[0] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            regs <= '{default: ext_irq_pkg::REG_RESET};
            bus_state <= ext_irq_pkg::BUS_IDLE;
            avs_readdata <= ext_irq_pkg::UNMAPPED_READ;
            buffers_off <= 4'h0;
        end else if (clk_en) begin
            regs <= next_regs;
            bus_state <= next_bus_state;
            avs_readdata <= next_readdata;
            buffers_off <= next_buffers_off;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Samples taken on every enabled clock; edges of upper pins need this clock running
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pin_sample <= 8'hFF;
            pc_sample <= 8'h00;
        end else if (clk_en) begin
            pin_sample <= pin_seen;
            pc_sample <= pin_change_inputs;
        end
    end
    // Pin-change samples start from zero; the vector is held off until the first enabled clock
    logic pc_primed;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pc_primed <= 1'b0;
        end else if (clk_en) begin
            pc_primed <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Requests are combinational so a low level is seen without a clock edge
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            if (level_mode[n]) begin
                ext_irq_request[n] = low_now[n] && regs.ext_interrupt_mask[n] && global_irq_enable;
            end else begin
                ext_irq_request[n] = regs.ext_interrupt_flags[n] && regs.ext_interrupt_mask[n]
                                     && global_irq_enable;
            end
        end
    end

    assign pin_change_vector = regs.pin_change_flags[0] && regs.pin_change_control[ext_irq_pkg::GROUP_BIT]
                               && global_irq_enable && pc_primed;

    ////////////////////////////////////////////////////////////////////////
    flag_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !global_irq_enable |-> ext_irq_request == 8'h00 && !pin_change_vector)
        else $error("request raised with global enable low");

    mask_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (ext_irq_request & ~regs.ext_interrupt_mask) == 8'h00)
        else $error("request raised on a masked source");

    edge_sets_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_en && trig[5] && !level_mode[5] |=> regs.ext_interrupt_flags[5])
        else $error("edge did not set its flag");

    level_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_en && level_mode[5] |=> !regs.ext_interrupt_flags[5])
        else $error("level-sensed flag not held clear");

    ack_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_en && ext_irq_ack[6] && !trig[6] |=> !regs.ext_interrupt_flags[6])
        else $error("acknowledge did not clear flag");

    level_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        level_mode[5] && !ext_irq_pin[5] && regs.ext_interrupt_mask[5] && global_irq_enable
        |-> ext_irq_request[5])
        else $error("low level not requesting");

    pc_sets_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_en && pc_trig |=> regs.pin_change_flags[0])
        else $error("pin change did not set group flag");

    pc_mask_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_en && regs.pin_change_mask == 8'h00 && !pin_change_ack && !wr_hit
        |=> $stable(regs.pin_change_flags))
        else $error("unmasked pins changed the group flag");

    wait_one_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_en && rd_hit |=> !avs_waitrequest)
        else $error("bus answer late");

    edge_req_c: cover property (@(posedge ref_clk) disable iff (!nrst) ext_irq_request[5] && !level_mode[5]);
    level_req_c: cover property (@(posedge ref_clk) disable iff (!nrst) ext_irq_request[1] && level_mode[1]);
    pc_vec_c: cover property (@(posedge ref_clk) disable iff (!nrst) pin_change_vector);
    sleep_c: cover property (@(posedge ref_clk) disable iff (!nrst) buffers_off != 4'h0);

endmodule

// ---- verif/pin_cpu_model.sv ----
module pin_cpu_model (
    // Clock
    input  wire logic       ref_clk,
    // Levels and mode chosen by the bench
    input  wire logic [7:0] pin_level,
    input  wire logic [7:0] pc_level,
    input  wire logic       auto_ack,
    // Requests from the block
    input  wire logic [7:0] ext_irq_request,
    input  wire logic       pin_change_vector,
    // Pins and vector entry towards the block
    output logic [7:0]      ext_irq_pin = 8'hFF,
    output logic [7:0]      pin_change_inputs = 8'h00,
    output logic [7:0]      ext_irq_ack = 8'h00,
    output logic            pin_change_ack = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pins take the bench's level one edge later and hold it, a low level included, until told otherwise
    always_ff @(posedge ref_clk) begin
        ext_irq_pin       <= pin_level;
        pin_change_inputs <= pc_level;
    end

    // Vector entry: one pulse per pending request; never two in a row, as a real CPU needs cycles to enter
    always_ff @(posedge ref_clk) begin
        ext_irq_ack    <= auto_ack ? (ext_irq_request & ~ext_irq_ack) : 8'h00;
        pin_change_ack <= auto_ack & pin_change_vector & ~pin_change_ack;
    end
endmodule

// ---- verif/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        clk_en = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  pin_level = 8'hFF;
    logic [7:0]  pc_level = 8'h00;
    logic        auto_ack = 1'b0;
    logic        global_irq_enable = 1'b0;
    logic        sleep_entry = 1'b0;
    logic [7:0]  ext_irq_pin, pin_change_inputs, ext_irq_ack, ext_irq_request;
    logic        pin_change_ack, pin_change_vector;
    logic [3:0]  lower_buffer_enable;
    logic [7:0]  lower_sh = 8'h00, upper_sh = 8'h00;
    int          errors = 0, n_tests = 0;

    initial forever #5 ref_clk = ~ref_clk;

    external_pin_interrupt_ctrl DUT (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_irq_pin(ext_irq_pin),
        .pin_change_inputs(pin_change_inputs), .global_irq_enable(global_irq_enable), .sleep_entry(sleep_entry),
        .ext_irq_ack(ext_irq_ack), .pin_change_ack(pin_change_ack), .ext_irq_request(ext_irq_request),
        .pin_change_vector(pin_change_vector), .lower_buffer_enable(lower_buffer_enable));

    pin_cpu_model far_side (.ref_clk(ref_clk), .pin_level(pin_level), .pc_level(pc_level), .auto_ack(auto_ack),
        .ext_irq_request(ext_irq_request), .pin_change_vector(pin_change_vector), .ext_irq_pin(ext_irq_pin),
        .pin_change_inputs(pin_change_inputs), .ext_irq_ack(ext_irq_ack), .pin_change_ack(pin_change_ack));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Holds the request until waitrequest is seen low; the wait count guards against a hung slave
    task automatic bus(input logic wr, input logic [2:0] idx, input logic [7:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, wd};
        avs_write <= wr;
        avs_read <= ~wr;
        // Look between edges, so the value seen is the one the next rising edge samples
        @(negedge ref_clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            n++;
            @(negedge ref_clk);
        end
        if (n == 50) errors++;
        rd = avs_readdata;
        @(posedge ref_clk);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, idx, d, r);
    endtask

    task automatic rd_check(input string what, input logic [2:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        bus(1'b0, idx, 8'h00, r);
        check(what, r, {24'h000000, exp});
    endtask

    task automatic set_sense(input int src, input logic [1:0] mode);
        wr(ext_irq_pkg::OFS_MASK, 8'h00);
        if (src < 4) begin
            lower_sh[2*src +: 2] = mode;
            wr(ext_irq_pkg::OFS_LOWER_SENSE, lower_sh);
        end else begin
            upper_sh[2*(src-4) +: 2] = mode;
            wr(ext_irq_pkg::OFS_UPPER_SENSE, upper_sh);
        end
        wr(ext_irq_pkg::OFS_FLAGS, 8'hFF);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int i = 0; i < 8; i++) rd_check("reset value", 3'(i), 8'h00);
        avs_byteenable <= 4'h0;
        wr(ext_irq_pkg::OFS_PC_MASK, 8'h5A);
        avs_byteenable <= 4'hF;
        rd_check("write without byte0", ext_irq_pkg::OFS_PC_MASK, 8'h00);
        wr(ext_irq_pkg::OFS_PC_MASK, 8'hA5);
        rd_check("pin change mask", ext_irq_pkg::OFS_PC_MASK, 8'hA5);
    endtask

    // One lower and one upper source through all four sense modes
    task automatic t_sense();
        int src;
        logic [7:0] b;
        for (int k = 0; k < 2; k++) begin
            src = k ? 5 : 1;
            b = 8'h01 << src;
            for (int m = 0; m < 4; m++) begin
                set_sense(src, 2'(m));
                wr(ext_irq_pkg::OFS_MASK, b);
                pin_level <= pin_level & ~b;
                tick(4);
                @(negedge ref_clk);
                check("request after fall", {24'h0, ext_irq_request}, (m != 3) ? {24'h0, b} : 32'h0);
                rd_check("flag after fall", ext_irq_pkg::OFS_FLAGS, (m == 1 || m == 2) ? b : 8'h00);
                wr(ext_irq_pkg::OFS_FLAGS, b);
                pin_level <= pin_level | b;
                tick(4);
                rd_check("flag after rise", ext_irq_pkg::OFS_FLAGS, (m == 1 || m == 3) ? b : 8'h00);
            end
        end
    endtask

    task automatic t_mask();
        set_sense(6, ext_irq_pkg::SENSE_FALLING);
        pin_level <= pin_level & 8'hBF;
        tick(2);
        pin_level <= pin_level | 8'h40;
        tick(3);
        @(negedge ref_clk);
        check("request while masked", {24'h0, ext_irq_request}, 32'h0);
        rd_check("flag from short pulse", ext_irq_pkg::OFS_FLAGS, 8'h40);
        global_irq_enable <= 1'b0;
        wr(ext_irq_pkg::OFS_MASK, 8'h40);
        @(negedge ref_clk);
        check("request without global", {24'h0, ext_irq_request}, 32'h0);
        wr(ext_irq_pkg::OFS_FLAGS, 8'h00);
        global_irq_enable <= 1'b1;
        tick(1);
        @(negedge ref_clk);
        check("request enabled", {24'h0, ext_irq_request}, 32'h40);
        rd_check("flag after zero write", ext_irq_pkg::OFS_FLAGS, 8'h40);
        auto_ack <= 1'b1;
        tick(3);
        rd_check("flag after vector entry", ext_irq_pkg::OFS_FLAGS, 8'h00);
        auto_ack <= 1'b0;
    endtask

    task automatic t_pin_change();
        wr(ext_irq_pkg::OFS_PC_MASK, 8'h04);
        wr(ext_irq_pkg::OFS_PC_CONTROL, 8'h01);
        pc_level <= 8'h08;
        tick(4);
        rd_check("change on masked-off pin", ext_irq_pkg::OFS_PC_FLAGS, 8'h00);
        pc_level <= 8'h0C;
        tick(4);
        rd_check("group flag", ext_irq_pkg::OFS_PC_FLAGS, 8'h01);
        @(negedge ref_clk);
        check("group vector", {31'h0, pin_change_vector}, 32'h1);
        wr(ext_irq_pkg::OFS_PC_FLAGS, 8'h01);
        @(negedge ref_clk);
        check("vector after clear", {31'h0, pin_change_vector}, 32'h0);
        pc_level <= 8'h08;
        auto_ack <= 1'b1;
        tick(5);
        rd_check("group flag after entry", ext_irq_pkg::OFS_PC_FLAGS, 8'h00);
        auto_ack <= 1'b0;
    endtask

    // A change made and undone while the clock enable is low must leave no trace
    task automatic t_freeze();
        clk_en <= 1'b0;
        pc_level <= 8'h0C;
        tick(3);
        pc_level <= 8'h08;
        tick(3);
        clk_en <= 1'b1;
        tick(2);
        rd_check("group flag after frozen change", ext_irq_pkg::OFS_PC_FLAGS, 8'h00);
    endtask

    task automatic t_sleep();
        wr(ext_irq_pkg::OFS_MASK, 8'h01);
        sleep_entry <= 1'b1;
        tick(2);
        @(negedge ref_clk);
        check("buffers asleep", {28'h0, lower_buffer_enable}, 32'h1);
        @(posedge ref_clk);
        sleep_entry <= 1'b0;
        tick(2);
        @(negedge ref_clk);
        check("buffers awake", {28'h0, lower_buffer_enable}, 32'hF);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        tick(12);
        nrst <= 1'b1;
        global_irq_enable <= 1'b1;
        t_reset();
        t_sense();
        t_mask();
        t_pin_change();
        t_freeze();
        t_sleep();
        test_done();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        #300000;
        errors++;
        test_done();
    end
endmodule
